// File: rtl/sync_control_status_pins.sv
// Control and status pin logic of a multi-loop clock synchroniser
//
// Our own choices: the plain strobed port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "sync_ctl_regs.svh"

// Overview of operation
// - Interrupt pin low after any unmasked status change
// - Reset pin low resets registers, flags, offsets and enables
// - Reset loads every register default value
// - Clock outputs disabled while reset held
// - Each enable pin gated by own mask
// - First enable mask defaults to all outputs
// - Second and third masks default empty
// - Lock pins low unlocked, high locked
// - Signal pins mirror loss status bits
// - Step pin lowers selected loop frequency
// - Step size comes from software register
// - Loop mask selects loops that step
module sync_control_status_pins
    import sync_ctl_pkg::*;
(
    input  wire logic           ref_clk,
    input  wire logic           reset,
    input  wire logic           clk_en,
    input  wire logic [7:0]     reg_addr,
    input  wire logic [31:0]    reg_wdata,
    input  wire logic           reg_wr,
    input  wire logic           reg_rd,
    output var  logic [31:0]    reg_rdata,
    input  wire logic           device_reset_n,
    input  wire logic           out_enable_n_first,
    input  wire logic           out_enable_n_second,
    input  wire logic           out_enable_n_third,
    input  wire logic           freq_step_down,
    input  wire loop_state_s    loop_state,
    output var  logic           status_irq_n,
    output var  logic           unlocked_n_loop_first,
    output var  logic           unlocked_n_loop_third,
    output var  logic           unlocked_n_loop_fourth,
    output var  logic           no_signal_n_input_first,
    output var  logic           no_signal_n_input_second,
    output var  logic           no_signal_n_input_third,
    output var  logic [6:0]     out_clk_enable,
    output var  logic [2:0]     freq_step_loop_pulse,
    output var  logic [15:0]    freq_step_size,
    output var  loop_offsets_t  freq_offset
);

    pin_in_s       pins_raw;           // Raw board pins
    pin_in_s       pins_meta_ff;       // First synchroniser stage
    pin_in_s       pins_sync_ff;       // Second synchroniser stage
    logic          step_prev_ff;       // Step pin one cycle earlier
    logic          dev_rst;            // Device reset pin held low
    logic          step_edge;          // Rising edge on the step pin
    oe_masks_t     oe_mask_ff;         // Output enable masks
    logic [2:0]    step_mask_ff;       // Loops that follow the step pin
    logic [15:0]   step_size_ff;       // Step size per request
    logic [6:0]    irq_flag_ff;        // Sticky event flags
    logic [6:0]    irq_mask_ff;        // Interrupt enables
    logic [6:0]    nxt_irq_flag;       // Flags after set and clear
    logic [6:0]    events;             // Events of this cycle
    logic          irq_any;            // Any unmasked flag set
    loop_state_s   state_prev_ff;      // Monitor results one cycle earlier
    logic [6:0]    oe_calc;            // Output enables before the flop
    logic [6:0]    out_clk_en_ff;      // Registered output enables
    logic          irq_n_ff;           // Registered interrupt pin
    logic [2:0]    unlocked_n_ff;      // Registered lock pins
    logic [2:0]    no_signal_n_ff;     // Registered signal pins
    logic [2:0]    step_pulse_ff;      // Registered step pulses
    loop_offsets_t offset_ff;          // Accumulated offsets
    logic [31:0]   rdata_ff;           // Read data
    logic [31:0]   nxt_rdata;          // Read data before the flop

    assign pins_raw = '{step_down: freq_step_down,
                        oe_n:      {out_enable_n_third, out_enable_n_second, out_enable_n_first},
                        reset_n:   device_reset_n};

    // Two-stage synchroniser for all board pins
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            pins_meta_ff <= '{step_down: 1'b0, oe_n: 3'h7, reset_n: 1'b0};
            pins_sync_ff <= '{step_down: 1'b0, oe_n: 3'h7, reset_n: 1'b0};
        end else if (clk_en) begin
            pins_meta_ff <= pins_raw;
            pins_sync_ff <= pins_meta_ff;
        end
    end

    // Device reset pin acts as a synchronous reset of registers, flags, offsets and enables
    assign dev_rst   = !pins_sync_ff.reset_n;
    assign step_edge = pins_sync_ff.step_down && !step_prev_ff;

    // Step pin history for edge detection
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            step_prev_ff <= 1'b0;
        end else if (clk_en) begin
            step_prev_ff <= dev_rst ? 1'b0 : pins_sync_ff.step_down;
        end
    end

    // Software configuration registers
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            oe_mask_ff   <= {`OE_MASK_OTHER_RST, `OE_MASK_OTHER_RST, `OE_MASK_FIRST_RST};
            step_mask_ff <= `STEP_LOOP_MASK_RST;
            step_size_ff <= `STEP_SIZE_RST;
            irq_mask_ff  <= `IRQ_MASK_RST;
        end else if (clk_en) begin
            if (dev_rst) begin
                // Defaults, first pin controls all outputs
                oe_mask_ff   <= {`OE_MASK_OTHER_RST, `OE_MASK_OTHER_RST, `OE_MASK_FIRST_RST};
                step_mask_ff <= `STEP_LOOP_MASK_RST;
                step_size_ff <= `STEP_SIZE_RST;
                irq_mask_ff  <= `IRQ_MASK_RST;
            end else if (reg_wr) begin
                case (reg_addr)
                    `REG_OE_MASK_FIRST:  oe_mask_ff[0] <= reg_wdata[6:0];
                    `REG_OE_MASK_SECOND: oe_mask_ff[1] <= reg_wdata[6:0];
                    `REG_OE_MASK_THIRD:  oe_mask_ff[2] <= reg_wdata[6:0];
                    `REG_STEP_LOOP_MASK: step_mask_ff  <= reg_wdata[2:0];
                    `REG_STEP_SIZE:      step_size_ff  <= reg_wdata[15:0];
                    `REG_IRQ_MASK:       irq_mask_ff   <= reg_wdata[6:0];
                    default: begin
                        // Other addresses hold nothing writable
                    end
                endcase
            end
        end
    end

    // Status change events: lock or signal change, step taken
    assign events = {step_edge && (step_mask_ff != 3'h0),
                     loop_state.signal_lost ^ state_prev_ff.signal_lost,
                     loop_state.locked ^ state_prev_ff.locked};

    // Sticky flags, a new event wins over a write-one clear
    always_comb begin
        nxt_irq_flag = irq_flag_ff;
        if (reg_wr && (reg_addr == `REG_IRQ_FLAGS)) begin
            nxt_irq_flag = irq_flag_ff & ~reg_wdata[6:0];
        end
        nxt_irq_flag = nxt_irq_flag | events;
    end

    assign irq_any = |(irq_flag_ff & irq_mask_ff);

    // Flags, monitor history and interrupt pin
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            irq_flag_ff   <= 7'h00;
            state_prev_ff <= '{signal_lost: 3'h0, locked: 3'h0};
            irq_n_ff      <= 1'b1;
        end else if (clk_en) begin
            state_prev_ff <= loop_state;
            if (dev_rst) begin
                irq_flag_ff <= 7'h00;
                irq_n_ff    <= 1'b1;
            end else begin
                irq_flag_ff <= nxt_irq_flag;
                irq_n_ff    <= !irq_any;
            end
        end
    end

    // An output is enabled unless a pin that controls it is high
    genvar o;
    generate
        for (o = 0; o < 7; o = o + 1) begin : g_oe
            assign oe_calc[o] = !(|({oe_mask_ff[2][o], oe_mask_ff[1][o], oe_mask_ff[0][o]}
                                    & pins_sync_ff.oe_n));
        end
    endgenerate

    // Output enables and status pins
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            out_clk_en_ff  <= 7'h00;
            unlocked_n_ff  <= 3'h0;
            no_signal_n_ff <= 3'h0;
        end else if (clk_en) begin
            out_clk_en_ff  <= dev_rst ? 7'h00 : oe_calc;
            unlocked_n_ff  <= loop_state.locked;
            no_signal_n_ff <= ~loop_state.signal_lost;
        end
    end

    // One step down per rising edge on selected loops
    genvar l;
    generate
        for (l = 0; l < 3; l = l + 1) begin : g_step
            always_ff @(posedge ref_clk or posedge reset) begin
                if (reset) begin
                    step_pulse_ff[l] <= 1'b0;
                    offset_ff[l]     <= `OFFSET_RST;
                end else if (clk_en) begin
                    if (dev_rst) begin
                        step_pulse_ff[l] <= 1'b0;
                        offset_ff[l]     <= `OFFSET_RST;
                    end else begin
                        step_pulse_ff[l] <= step_edge && step_mask_ff[l];
                        if (step_pulse_ff[l]) begin
                            offset_ff[l] <= offset_ff[l] - {8'h00, step_size_ff};
                        end
                    end
                end
            end
        end
    endgenerate

    // Read multiplexer, unmapped addresses read zero
    always_comb begin
        case (reg_addr)
            `REG_OE_MASK_FIRST:  nxt_rdata = {25'h0000000, oe_mask_ff[0]};
            `REG_OE_MASK_SECOND: nxt_rdata = {25'h0000000, oe_mask_ff[1]};
            `REG_OE_MASK_THIRD:  nxt_rdata = {25'h0000000, oe_mask_ff[2]};
            `REG_STEP_LOOP_MASK: nxt_rdata = {29'h00000000, step_mask_ff};
            `REG_STEP_SIZE:      nxt_rdata = {16'h0000, step_size_ff};
            `REG_LIVE_STATUS:    nxt_rdata = {26'h0000000, loop_state};
            `REG_IRQ_FLAGS:      nxt_rdata = {25'h0000000, irq_flag_ff};
            `REG_IRQ_MASK:       nxt_rdata = {25'h0000000, irq_mask_ff};
            `REG_OFFSET_FIRST:   nxt_rdata = {8'h00, offset_ff[0]};
            `REG_OFFSET_SECOND:  nxt_rdata = {8'h00, offset_ff[1]};
            `REG_OFFSET_THIRD:   nxt_rdata = {8'h00, offset_ff[2]};
            default:             nxt_rdata = 32'h00000000;
        endcase
    end

    // Read data stands for one cycle after the strobe
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            rdata_ff <= 32'h00000000;
        end else if (clk_en) begin
            rdata_ff <= reg_rd ? nxt_rdata : 32'h00000000;
        end
    end

    // Ports straight from flops
    assign reg_rdata                = rdata_ff;
    assign status_irq_n             = irq_n_ff;
    assign unlocked_n_loop_first    = unlocked_n_ff[0];
    assign unlocked_n_loop_third    = unlocked_n_ff[1];
    assign unlocked_n_loop_fourth   = unlocked_n_ff[2];
    assign no_signal_n_input_first  = no_signal_n_ff[0];
    assign no_signal_n_input_second = no_signal_n_ff[1];
    assign no_signal_n_input_third  = no_signal_n_ff[2];
    assign out_clk_enable           = out_clk_en_ff;
    assign freq_step_loop_pulse     = step_pulse_ff;
    assign freq_step_size           = step_size_ff;
    assign freq_offset              = offset_ff;

    // Interrupt pin follows unmasked flags one cycle later
    AST_IRQ_FOLLOWS: assert property (@(posedge ref_clk) disable iff (reset)
        (clk_en && !dev_rst) |=> (status_irq_n == !$past(irq_any)))
        else $error("interrupt pin does not follow flags");

    // Reset pin returns steering state to defaults
    AST_DEVRST_CLEARS: assert property (@(posedge ref_clk) disable iff (reset)
        (clk_en && dev_rst) |=> (step_mask_ff == 3'h0 && irq_flag_ff == 7'h00
                                 && step_size_ff == `STEP_SIZE_RST && status_irq_n))
        else $error("device reset left state behind");

    // Clock outputs off while the reset pin is held
    AST_DEVRST_OUTS_OFF: assert property (@(posedge ref_clk) disable iff (reset)
        (clk_en && dev_rst) |=> (out_clk_enable == 7'h00))
        else $error("clock output enabled during reset");

    // A high first pin disables every output in its mask
    AST_OE_GATE: assert property (@(posedge ref_clk) disable iff (reset)
        (clk_en && !dev_rst && pins_sync_ff.oe_n[0]) |=> ((out_clk_enable & $past(oe_mask_ff[0])) == 7'h00))
        else $error("masked output stays enabled");

    // Mask defaults after a reset pin pulse
    AST_MASK_DEFAULTS: assert property (@(posedge ref_clk) disable iff (reset)
        (clk_en && dev_rst) |=> (oe_mask_ff[0] == 7'h7F && oe_mask_ff[1] == 7'h00 && oe_mask_ff[2] == 7'h00))
        else $error("enable masks not at defaults");

    // Lock pins high exactly when the loop is locked
    AST_LOCK_PINS: assert property (@(posedge ref_clk) disable iff (reset)
        clk_en |=> ({unlocked_n_loop_fourth, unlocked_n_loop_third, unlocked_n_loop_first}
                    == $past(loop_state.locked)))
        else $error("lock pin disagrees with loop");

    // Signal pins mirror the loss status bits
    AST_SIGNAL_PINS: assert property (@(posedge ref_clk) disable iff (reset)
        clk_en |=> ({no_signal_n_input_third, no_signal_n_input_second, no_signal_n_input_first}
                    == ~$past(loop_state.signal_lost)))
        else $error("signal pin disagrees with status");

    // One pulse per edge, only on masked loops, then quiet
    AST_STEP_ONCE: assert property (@(posedge ref_clk) disable iff (reset)
        (clk_en && !dev_rst && step_edge) |=> (freq_step_loop_pulse == $past(step_mask_ff))
                                              ##1 (!clk_en || freq_step_loop_pulse == 3'h0))
        else $error("step pulse wrong");

    // Each first-loop pulse lowers its offset by the programmed size
    AST_STEP_SIZE: assert property (@(posedge ref_clk) disable iff (reset)
        (clk_en && !dev_rst && step_pulse_ff[0]) |=>
            (offset_ff[0] == 24'($past(offset_ff[0]) - {8'h00, $past(step_size_ff)})))
        else $error("offset step wrong");

    // Interrupt holds low while nothing clears it
    AST_IRQ_HOLD: assert property (@(posedge ref_clk) disable iff (reset)
        (!status_irq_n && clk_en && !dev_rst && !reg_wr && irq_any) |=> !status_irq_n)
        else $error("interrupt released without clear");

endmodule
`default_nettype wire

// File: rtl/sync_ctl_pkg.sv
// Types shared by the control and status pin block
package sync_ctl_pkg;

    // Monitor results from the synthesis loops and input monitors
    typedef struct packed {
        logic [2:0] signal_lost;  // Per clock input, high when lost
        logic [2:0] locked;       // Per synthesis loop, high when locked
    } loop_state_s;

    // Pins sampled from the board, all active low except the step pin
    typedef struct packed {
        logic       step_down;    // Frequency step down request
        logic [2:0] oe_n;         // Output enable pins, first at bit 0
        logic       reset_n;      // Device reset pin
    } pin_in_s;

    // Accumulated frequency offset per synthesis loop
    typedef logic [2:0][23:0] loop_offsets_t;

    // Output enable mask per output enable pin
    typedef logic [2:0][6:0]  oe_masks_t;

endpackage

// File: rtl/sync_ctl_regs.svh
// Register offsets, field positions, reset values and timing constants of the control and status pin block
`ifndef SYNC_CTL_REGS_SVH
`define SYNC_CTL_REGS_SVH

// Byte offsets on the register port
`define REG_OE_MASK_FIRST   8'h00
`define REG_OE_MASK_SECOND  8'h04
`define REG_OE_MASK_THIRD   8'h08
`define REG_STEP_LOOP_MASK  8'h0C
`define REG_STEP_SIZE       8'h10
`define REG_LIVE_STATUS     8'h14
`define REG_IRQ_FLAGS       8'h18
`define REG_IRQ_MASK        8'h1C
`define REG_OFFSET_FIRST    8'h20
`define REG_OFFSET_SECOND   8'h24
`define REG_OFFSET_THIRD    8'h28

// Reset values
`define OE_MASK_FIRST_RST   7'h7F
`define OE_MASK_OTHER_RST   7'h00
`define STEP_LOOP_MASK_RST  3'h0
`define STEP_SIZE_RST       16'h0001
`define IRQ_MASK_RST        7'h00
`define OFFSET_RST          24'h000000

// Field positions in the flag, mask and live status registers
`define FLD_LOCK_LSB        0
`define FLD_SIGNAL_LSB      3
`define FLD_STEP_BIT        6

// Synchroniser depth for pin inputs
`define SYNC_STAGES         2

`endif

// File: verif/board_model.sv
// Board side model that presses the frequency step down pin
`timescale 1ns/1ns
`default_nettype none
module board_model (
    input  wire logic ref_clk,         // Block clock
    input  wire logic reset,           // Async reset, active high
    input  wire logic step_req,        // Request one press from the bench
    output var  logic freq_step_down   // Step pin towards the block
);
    logic [3:0] hold_ff;               // Press phase counter

    // Pin high four cycles, then low four before another press is taken
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            hold_ff <= 4'h0;
        end else if (step_req && hold_ff == 4'h0) begin
            hold_ff <= 4'h8;
        end else if (hold_ff != 4'h0) begin
            hold_ff <= hold_ff - 4'h1;
        end
    end

    // Held high over several edges, so the block must step once only
    always_comb begin
        freq_step_down = hold_ff > 4'h4;
    end
endmodule
`default_nettype wire

// File: verif/test_sync_control_status_pins.sv
// Self-checking bench of the control and status pin block
`timescale 1ns/1ns
`default_nettype none
`include "sync_ctl_regs.svh"
module test_sync_control_status_pins
    import sync_ctl_pkg::*;
;
    logic          ref_clk, reset, clk_en, reg_wr, reg_rd, step_req;
    logic [7:0]    reg_addr;
    logic [31:0]   reg_wdata, reg_rdata;
    logic          device_reset_n, out_enable_n_first, out_enable_n_second, out_enable_n_third;
    wire logic     freq_step_down;
    loop_state_s   loop_state;
    logic          status_irq_n, unlocked_n_loop_first, unlocked_n_loop_third, unlocked_n_loop_fourth;
    logic          no_signal_n_input_first, no_signal_n_input_second, no_signal_n_input_third;
    logic [6:0]    out_clk_enable, en;
    logic [2:0]    freq_step_loop_pulse, lm;
    logic [15:0]   freq_step_size, sz;
    loop_offsets_t freq_offset;
    integer        fails = 0, tests_run = 0, cycles = 0, seed = 32'h981f722c;
    logic [31:0]   exp_q[$];           // Expected read data, oldest first
    string         name_q[$];          // Names of pending reads
    logic          rd_seen = 1'b0;     // A read was taken last edge
    logic [23:0]   exp_off[3];         // Expected offset per loop
    logic [6:0]    mask_v[3];          // Enable masks written
    logic [2:0]    pin_v;              // Enable pin levels
    logic [31:0]   dflt[12];           // Default read table
    int            i, s, n;

    sync_control_status_pins dut (.ref_clk(ref_clk), .reset(reset), .clk_en(clk_en), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .device_reset_n(device_reset_n), .out_enable_n_first(out_enable_n_first),
        .out_enable_n_second(out_enable_n_second), .out_enable_n_third(out_enable_n_third),
        .freq_step_down(freq_step_down), .loop_state(loop_state), .status_irq_n(status_irq_n),
        .unlocked_n_loop_first(unlocked_n_loop_first), .unlocked_n_loop_third(unlocked_n_loop_third),
        .unlocked_n_loop_fourth(unlocked_n_loop_fourth), .no_signal_n_input_first(no_signal_n_input_first),
        .no_signal_n_input_second(no_signal_n_input_second), .no_signal_n_input_third(no_signal_n_input_third),
        .out_clk_enable(out_clk_enable), .freq_step_loop_pulse(freq_step_loop_pulse),
        .freq_step_size(freq_step_size), .freq_offset(freq_offset));
    board_model partner (.ref_clk(ref_clk), .reset(reset), .step_req(step_req), .freq_step_down(freq_step_down));

    // Clock, 10 ns period
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // Compare one value and count it
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run = tests_run + 1;
        if (seen !== exp) begin
            fails = fails + 1;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Print the counts and the verdict, then stop
    task automatic summarize();
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // One-cycle register write
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    // One-cycle register read, expectation noted for the watcher
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        exp_q.push_back(e);
        name_q.push_back(nm);
        @(posedge ref_clk);
        reg_rd <= 1'b0;
    endtask

    // Wait k edges and let their updates land
    task automatic settle(input int k);
        repeat (k) @(posedge ref_clk);
        #1;
    endtask

    // Watcher: read data stand in the cycle after the strobe
    always @(posedge ref_clk) begin
        if (rd_seen) begin
            check(name_q.pop_front(), reg_rdata, exp_q.pop_front());
        end
        rd_seen <= reg_rd;
    end

    // Hang guard
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails = fails + 1;
            summarize();
        end
    end

    // Main sequence
    initial begin
        {reset, clk_en, reg_wr, reg_rd, step_req, reg_addr, reg_wdata} = {2'b11, 43'h0};
        {device_reset_n, out_enable_n_first, out_enable_n_second, out_enable_n_third} = 4'h8;
        loop_state = 6'h07;
        exp_off = '{24'h0, 24'h0, 24'h0};
        settle(2);
        check("enables in reset", 32'(out_clk_enable), 32'h0);
        check("irq in reset", 32'(status_irq_n), 32'h1);
        @(posedge ref_clk);
        reset <= 1'b0;
        settle(6);
        dflt = '{32'h7F, 0, 0, 0, 32'h1, 32'h7, 0, 0, 0, 0, 0, 0};
        for (i = 0; i < 12; i++) rd(8'(i * 4), dflt[i], "default");
        check("all enabled", 32'(out_clk_enable), 32'h7F);
        @(posedge ref_clk);
        {out_enable_n_third, out_enable_n_second, out_enable_n_first} <= 3'b110;
        settle(5);
        check("second third unmasked", 32'(out_clk_enable), 32'h7F);
        @(posedge ref_clk);
        {out_enable_n_third, out_enable_n_second, out_enable_n_first} <= 3'b001;
        settle(5);
        check("first disables all", 32'(out_clk_enable), 32'h0);
        $display("test reset defaults done");
        for (s = 0; s < 8; s++) begin
            for (i = 0; i < 3; i++) begin
                mask_v[i] = 7'($random(seed));
                wr(8'(i * 4), 32'(mask_v[i]));
            end
            pin_v = 3'($random(seed));
            {out_enable_n_third, out_enable_n_second, out_enable_n_first} <= pin_v;
            en = 7'h7F;
            for (i = 0; i < 3; i++) if (pin_v[i]) en = en & ~mask_v[i];
            settle(5);
            check("gated enables", 32'(out_clk_enable), 32'(en));
        end
        $display("test enable masks done");
        for (s = 0; s < 6; s++) begin
            @(posedge ref_clk);
            loop_state <= 6'($random(seed));
            settle(3);
            check("lock pins",
                32'({unlocked_n_loop_fourth, unlocked_n_loop_third, unlocked_n_loop_first}), 32'(loop_state.locked));
            check("signal pins",
                32'({no_signal_n_input_third, no_signal_n_input_second, no_signal_n_input_first}),
                {29'h0, ~loop_state.signal_lost});
        end
        // Clock enable low freezes the pins although the loops change
        @(posedge ref_clk);
        clk_en <= 1'b0;
        loop_state.locked <= ~loop_state.locked;
        settle(4);
        check("frozen lock pins",
            32'({unlocked_n_loop_fourth, unlocked_n_loop_third, unlocked_n_loop_first}), {29'h0, ~loop_state.locked});
        @(posedge ref_clk);
        clk_en <= 1'b1;
        $display("test status pins done");
        wr(`REG_IRQ_FLAGS, 32'h7F);
        rd(`REG_IRQ_FLAGS, 32'h0, "flags cleared");
        wr(`REG_IRQ_MASK, 32'h1);
        loop_state.locked[0] <= ~loop_state.locked[0];
        settle(4);
        check("irq on change", 32'(status_irq_n), 32'h0);
        rd(`REG_IRQ_FLAGS, 32'h1, "lock flag");
        settle(3);
        check("irq holds", 32'(status_irq_n), 32'h0);
        wr(`REG_IRQ_FLAGS, 32'h1);
        loop_state.locked[1] <= ~loop_state.locked[1];
        settle(4);
        check("irq released, masked change", 32'(status_irq_n), 32'h1);
        wr(`REG_IRQ_FLAGS, 32'h7F);
        $display("test interrupt done");
        for (s = 0; s < 4; s++) begin
            lm = (s == 3) ? 3'h0 : (3'($random(seed)) | 3'h1);
            sz = 16'($random(seed));
            wr(`REG_STEP_LOOP_MASK, 32'(lm));
            wr(`REG_STEP_SIZE, 32'(sz));
            step_req <= 1'b1;
            @(posedge ref_clk);
            step_req <= 1'b0;
            n = 0;
            repeat (16) begin
                @(posedge ref_clk);
                #1;
                if (freq_step_loop_pulse !== 3'h0) begin
                    n = n + 1;
                    check("pulse loops", 32'(freq_step_loop_pulse), 32'(lm));
                end
            end
            check("one step per press", n, (lm != 3'h0) ? 1 : 0);
            check("step size", 32'(freq_step_size), 32'(sz));
            for (i = 0; i < 3; i++) begin
                if (lm[i]) exp_off[i] = exp_off[i] - 24'(sz);
                check("offset port", 32'(freq_offset[i]), 32'(exp_off[i]));
                rd(8'(8'h20 + i * 4), 32'(exp_off[i]), "offset");
            end
        end
        rd(`REG_IRQ_FLAGS, 32'h40, "step flag");
        wr(`REG_IRQ_MASK, 32'h40);
        settle(3);
        check("irq on step", 32'(status_irq_n), 32'h0);
        $display("test frequency step done");
        @(posedge ref_clk);
        device_reset_n <= 1'b0;
        wr(`REG_OE_MASK_FIRST, 32'h0);
        settle(5);
        check("enables in device reset", 32'(out_clk_enable), 32'h0);
        check("irq in device reset", 32'(status_irq_n), 32'h1);
        @(posedge ref_clk);
        device_reset_n <= 1'b1;
        settle(6);
        rd(`REG_OE_MASK_FIRST, 32'h7F, "mask after device reset");
        rd(`REG_OFFSET_FIRST, 32'h0, "offset after device reset");
        rd(`REG_IRQ_MASK, 32'h0, "irq mask after device reset");
        settle(3);
        $display("test device reset done");
        summarize();
    end
endmodule
`default_nettype wire
